// ### shared/agc_pkg.sv
// package for the gain-limit and carrier-sense configuration bank
// assumes a single 40 MHz clock domain and byte-wide register port
package agc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] GAIN_LIMIT_AND_TARGET_OFS           = 6'h1B;
  localparam logic [ADDR_W-1:0] GAIN_PRIORITY_AND_CARRIER_SENSE_OFS = 6'h1C;
  localparam logic [7:0] GAIN_LIMIT_AND_TARGET_RST           = 8'h03;
  localparam logic [7:0] GAIN_PRIORITY_AND_CARRIER_SENSE_RST = 8'h40;
  localparam logic [7:0] PRIO_CS_WRITE_MASK                  = 8'h7F;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int DIG_CEIL_LSB  = 6;
  localparam int FRONT_CEIL_LSB = 3;
  localparam int TARGET_LSB    = 0;
  localparam int ORDER_BIT     = 6;
  localparam int REL_THR_LSB   = 4;
  localparam int ABS_THR_LSB   = 0;

  // ----------------------------------------------------------------
  // encodings and figures
  // ----------------------------------------------------------------
  localparam logic [3:0] ABS_THR_DISABLED = 4'h8;
  localparam logic [1:0] REL_THR_OFF      = 2'h0;
  localparam logic [2:0] DIG_TOP_STEP     = 3'h7;
  localparam logic       ORDER_FIRST_AMP  = 1'b1;

  typedef struct packed {
    logic [1:0] digital_gain_ceiling;
    logic [2:0] front_amp_gain_ceiling;
    logic [2:0] amplitude_target;
  } agc_limit_type;

  typedef struct packed {
    logic       amp_reduction_order;
    logic [1:0] carrier_relative_threshold;
    logic [3:0] carrier_absolute_threshold;
  } agc_cs_cfg_type;

  typedef struct packed {
    agc_limit_type  limit;
    agc_cs_cfg_type cs_cfg;
    logic [7:0]     rdata;
    logic signed [7:0] base_rssi;
    logic           base_valid;
    logic           rel_latched;
    logic           carrier_sense;
    logic           reduce_first;
    logic           reduce_second;
    logic [2:0]     dig_max_step;
    logic [7:0]     front_backoff;
    logic [5:0]     target_db;
  } agc_state_type;

  // target amplitude in dB for each code
  function automatic logic [5:0] agc_target_db(input logic [2:0] code);
    case (code)
      3'h0:    agc_target_db = 6'h18;
      3'h1:    agc_target_db = 6'h1B;
      3'h2:    agc_target_db = 6'h1E;
      3'h3:    agc_target_db = 6'h21;
      3'h4:    agc_target_db = 6'h24;
      3'h5:    agc_target_db = 6'h26;
      3'h6:    agc_target_db = 6'h28;
      default: agc_target_db = 6'h2A;
    endcase
  endfunction : agc_target_db

  // front amplifier ceiling back-off in tenths of a dB
  function automatic logic [7:0] agc_front_backoff(input logic [2:0] code);
    case (code)
      3'h0:    agc_front_backoff = 8'h00;
      3'h1:    agc_front_backoff = 8'h1A;
      3'h2:    agc_front_backoff = 8'h3D;
      3'h3:    agc_front_backoff = 8'h4A;
      3'h4:    agc_front_backoff = 8'h5C;
      3'h5:    agc_front_backoff = 8'h73;
      3'h6:    agc_front_backoff = 8'h92;
      default: agc_front_backoff = 8'hAB;
    endcase
  endfunction : agc_front_backoff

  // relative rise in dB needed for carrier sense
  function automatic logic [4:0] agc_rel_step(input logic [1:0] code);
    case (code)
      2'h1:    agc_rel_step = 5'h06;
      2'h2:    agc_rel_step = 5'h0A;
      2'h3:    agc_rel_step = 5'h0E;
      default: agc_rel_step = 5'h00;
    endcase
  endfunction : agc_rel_step

endpackage : agc_pkg

// ### verilog/agc_cs_eval.sv
// carrier-sense comparators for one strength sample
// assumes the sample and baseline are in dB on the channel filter scale
`timescale 1ns/1ps
module agc_cs_eval import agc_pkg::*; (
  input  wire logic signed [7:0] i_rssi,
  input  wire logic signed [7:0] i_base_rssi,
  input  wire logic              i_base_valid,
  input  wire agc_cs_cfg_type    i_cfg,
  input  wire logic [2:0]        i_target_code,
  output logic                   o_abs_hit,
  output logic                   o_rel_hit
);

  logic signed [8:0] abs_ref;
  logic signed [8:0] rise;

  always_comb begin
    // ref = target + signed offset, 1 dB per step
    abs_ref   = $signed({3'h0, agc_target_db(i_target_code)})
              + $signed({{5{i_cfg.carrier_absolute_threshold[3]}}, i_cfg.carrier_absolute_threshold});
    o_abs_hit = (i_cfg.carrier_absolute_threshold != ABS_THR_DISABLED)
              && ($signed({i_rssi[7], i_rssi}) >= abs_ref);
    rise      = $signed({i_rssi[7], i_rssi}) - $signed({i_base_rssi[7], i_base_rssi});
    o_rel_hit = i_base_valid && (i_cfg.carrier_relative_threshold != REL_THR_OFF)
              && (rise >= $signed({4'h0, agc_rel_step(i_cfg.carrier_relative_threshold)}));
  end

endmodule : agc_cs_eval

// ### verilog/agc_gain_cfg.sv
// gain-limit, amplitude-target and carrier-sense configuration bank
// assumes a synchronous byte register port and a gain loop that reports stage limits
//
// What this block does
// - digital gain ceiling removes the top 1, 2 or 3 steps; 0 allows all.
// - front amplifier ceiling code 0 full gain, 1..7 lower ceiling stepwise.
// - amplitude target codes 0..7 map to 24..42 dB.
// - order bit 1: reduce first amplifier before any other reduction.
// - order bit 0: take second amplifier to minimum before reducing first.
// - relative threshold zero disables the relative carrier sense test.
// - relative codes 1..3 assert carrier sense on 6, 10, 14 dB rise.
// - absolute threshold is signed 1 dB steps around the amplitude target.
// - absolute threshold code -8 disables the absolute test.
// - absolute level is channel amplitude while no gain has been reduced.
`timescale 1ns/1ps
module agc_gain_cfg import agc_pkg::*; (
  input  wire logic              i_sys_clk,
  input  wire logic              i_sys_rst,
  input  wire logic [ADDR_W-1:0] i_reg_addr,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  input  wire logic [7:0]        i_reg_wdata,
  output logic [7:0]             o_reg_rdata,
  input  wire logic signed [7:0] i_rssi,
  input  wire logic              i_rssi_valid,
  input  wire logic              i_cs_clear,
  input  wire logic              i_reduce_req,
  input  wire logic              i_first_amp_at_min,
  input  wire logic              i_second_amp_at_min,
  output logic                   o_reduce_first,
  output logic                   o_reduce_second,
  output logic                   o_carrier_sense,
  output logic [2:0]             o_dig_max_step,
  output logic [7:0]             o_front_backoff,
  output logic [5:0]             o_target_db,
  output logic                   o_amp_reduction_order
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  agc_state_type state_ff;
  agc_state_type nxt_state;
  logic          abs_hit;
  logic          rel_hit;
  logic          rel_now;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // highest digital gain step left once the top steps are barred
  function automatic logic [2:0] dig_step_limit(input logic [1:0] ceiling);
    dig_step_limit = DIG_TOP_STEP - {1'b0, ceiling};
  endfunction : dig_step_limit

  // read-back image of one register; unmapped addresses read as zero
  function automatic logic [7:0] reg_image(input logic [ADDR_W-1:0] addr,
                                           input agc_limit_type     limit,
                                           input agc_cs_cfg_type    cs_cfg);
    case (addr)
      GAIN_LIMIT_AND_TARGET_OFS: begin
        reg_image = limit;
      end
      GAIN_PRIORITY_AND_CARRIER_SENSE_OFS: begin
        reg_image = {1'b0, cs_cfg};
      end
      default: begin
        reg_image = 8'h00;
      end
    endcase
  endfunction : reg_image

  // carrier sense after one sample: either criterion, or an earlier relative
  // rise that this cycle does not clear
  function automatic logic cs_level(input logic abs_now,
                                    input logic rel_now_hit,
                                    input logic latched,
                                    input logic clear);
    cs_level = abs_now || rel_now_hit || (latched && !clear);
  endfunction : cs_level

  // ----------------------------------------------------------------
  // reset image
  // ----------------------------------------------------------------
  // decoded outputs start in step with the register reset codes, so the
  // gain loop never sees a stale limit as reset is released
  localparam agc_limit_type  LIMIT_RST  = agc_limit_type'(GAIN_LIMIT_AND_TARGET_RST);
  localparam agc_cs_cfg_type CS_CFG_RST = agc_cs_cfg_type'(GAIN_PRIORITY_AND_CARRIER_SENSE_RST[6:0]);
  localparam agc_state_type  STATE_RST  = '{
    limit:         LIMIT_RST,
    cs_cfg:        CS_CFG_RST,
    rdata:         8'h00,
    base_rssi:     8'sh00,
    base_valid:    1'b0,
    rel_latched:   1'b0,
    carrier_sense: 1'b0,
    reduce_first:  1'b0,
    reduce_second: 1'b0,
    dig_max_step:  dig_step_limit(LIMIT_RST.digital_gain_ceiling),
    front_backoff: agc_front_backoff(LIMIT_RST.front_amp_gain_ceiling),
    target_db:     agc_target_db(LIMIT_RST.amplitude_target)
  };

  // ----------------------------------------------------------------
  // carrier-sense comparators
  // ----------------------------------------------------------------
  // they see the registered config, so a write takes effect from the next sample
  agc_cs_eval u_cs_eval (
    .i_rssi        (i_rssi),
    .i_base_rssi   (state_ff.base_rssi),
    .i_base_valid  (state_ff.base_valid),
    .i_cfg         (state_ff.cs_cfg),
    .i_target_code (state_ff.limit.amplitude_target),
    .o_abs_hit     (abs_hit),
    .o_rel_hit     (rel_hit)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    rel_now   = 1'b0;

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    // config is taken as static once reception runs
    if (i_reg_wr) begin
      case (i_reg_addr)
        GAIN_LIMIT_AND_TARGET_OFS: begin
          nxt_state.limit = agc_limit_type'(i_reg_wdata);
        end
        GAIN_PRIORITY_AND_CARRIER_SENSE_OFS: begin
          nxt_state.cs_cfg = agc_cs_cfg_type'(i_reg_wdata[6:0] & PRIO_CS_WRITE_MASK[6:0]);
        end
        default: begin
          // other addresses belong to neighbouring banks and are ignored here
        end
      endcase
    end
    if (i_reg_rd) begin
      nxt_state.rdata = reg_image(i_reg_addr, state_ff.limit, state_ff.cs_cfg);
    end

    // ----------------------------------------------------------------
    // decoded limits for the gain loop
    // ----------------------------------------------------------------
    // decoded one cycle behind the register so the gain loop sees a flop output
    nxt_state.dig_max_step  = dig_step_limit(state_ff.limit.digital_gain_ceiling);
    nxt_state.front_backoff = agc_front_backoff(state_ff.limit.front_amp_gain_ceiling);
    nxt_state.target_db     = agc_target_db(state_ff.limit.amplitude_target);

    // ----------------------------------------------------------------
    // amplifier reduction, one step per request
    // ----------------------------------------------------------------
    nxt_state.reduce_first  = 1'b0;
    nxt_state.reduce_second = 1'b0;
    if (i_reduce_req) begin
      if (state_ff.cs_cfg.amp_reduction_order == ORDER_FIRST_AMP) begin
        if (!i_first_amp_at_min) begin
          nxt_state.reduce_first = 1'b1;
        end else if (!i_second_amp_at_min) begin
          nxt_state.reduce_second = 1'b1;
        end
      end else begin
        if (!i_second_amp_at_min) begin
          nxt_state.reduce_second = 1'b1;
        end else if (!i_first_amp_at_min) begin
          nxt_state.reduce_first = 1'b1;
        end
      end
    end

    // ----------------------------------------------------------------
    // carrier sense
    // ----------------------------------------------------------------
    // a relative rise is latched until cleared; a rise in the clear cycle
    // still wins so a short burst is never lost
    if (i_rssi_valid) begin
      rel_now                 = rel_hit;
      nxt_state.base_rssi     = i_rssi;
      nxt_state.base_valid    = 1'b1;
      nxt_state.carrier_sense = cs_level(abs_hit, rel_hit, state_ff.rel_latched, i_cs_clear);
    end else if (i_cs_clear) begin
      nxt_state.carrier_sense = 1'b0;
    end
    if (rel_now) begin
      nxt_state.rel_latched = 1'b1;
    end else if (i_cs_clear) begin
      nxt_state.rel_latched = 1'b0;
      nxt_state.base_valid  = i_rssi_valid;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_ff <= STATE_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs, each straight from the state register
  // ----------------------------------------------------------------
  // the gain loop reads the decoded limits, never the raw fields
  assign o_reg_rdata           = state_ff.rdata;
  assign o_reduce_first        = state_ff.reduce_first;
  assign o_reduce_second       = state_ff.reduce_second;
  assign o_carrier_sense       = state_ff.carrier_sense;
  assign o_dig_max_step        = state_ff.dig_max_step;
  assign o_front_backoff       = state_ff.front_backoff;
  assign o_target_db           = state_ff.target_db;
  assign o_amp_reduction_order = state_ff.cs_cfg.amp_reduction_order;

endmodule : agc_gain_cfg

// ### test/agc_gain_cfg_monitor.sv
// checker for the gain-limit and carrier-sense bank
// assumes it is bound onto agc_gain_cfg and sees only its ports
`timescale 1ns/1ps
module agc_gain_cfg_monitor import agc_pkg::*; (
  input wire logic              i_sys_clk,
  input wire logic              i_sys_rst,
  input wire logic [ADDR_W-1:0] i_reg_addr,
  input wire logic              i_reg_wr,
  input wire logic              i_reg_rd,
  input wire logic [7:0]        i_reg_wdata,
  input wire logic [7:0]        o_reg_rdata,
  input wire logic signed [7:0] i_rssi,
  input wire logic              i_rssi_valid,
  input wire logic              i_cs_clear,
  input wire logic              i_reduce_req,
  input wire logic              i_first_amp_at_min,
  input wire logic              i_second_amp_at_min,
  input wire logic              o_reduce_first,
  input wire logic              o_reduce_second,
  input wire logic              o_carrier_sense,
  input wire logic [2:0]        o_dig_max_step,
  input wire logic [7:0]        o_front_backoff,
  input wire logic [5:0]        o_target_db,
  input wire logic              o_amp_reduction_order
);
  // ----
  // shadow of the carrier-sense register, rebuilt from writes
  // ----
  logic       lw;
  logic [7:0] cs_ff, wd1_ff, wd2_ff;
  logic [3:0] thr;
  assign lw  = i_reg_wr && i_reg_addr == GAIN_LIMIT_AND_TARGET_OFS;
  assign thr = cs_ff[3:0];
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) cs_ff <= GAIN_PRIORITY_AND_CARRIER_SENSE_RST;
    else if (i_reg_wr && i_reg_addr == GAIN_PRIORITY_AND_CARRIER_SENSE_OFS) cs_ff <= i_reg_wdata;
  end
  // decoded outputs trail a write by two cycles, so the data is delayed alike
  always_ff @(posedge i_sys_clk) begin
    wd1_ff <= i_reg_wdata;
    wd2_ff <= wd1_ff;
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_rise;
    i_rssi_valid && !i_cs_clear ##1 !i_rssi_valid && !i_cs_clear ##1 i_rssi_valid && cs_ff[5:4] != 2'h0
      && int'(i_rssi) - int'($past(i_rssi, 2)) >= 2 + 4 * int'(cs_ff[5:4]);
  endsequence
  property p_dig;
    lw |-> ##2 o_dig_max_step == 3'h7 - wd2_ff[7:6];
  endproperty
  a_dig: assert property (p_dig) else $error("digital ceiling wrong");
  property p_front;
    lw |-> ##2 (o_front_backoff == 8'h00) == (wd2_ff[5:3] == 3'h0);
  endproperty
  a_front: assert property (p_front) else $error("front ceiling wrong");
  property p_target;
    lw |-> ##2 int'(o_target_db) == (wd2_ff[2:0] < 3'h5 ? 24 + 3 * int'(wd2_ff[2:0]) : 28 + 2 * int'(wd2_ff[2:0]));
  endproperty
  a_target: assert property (p_target) else $error("target wrong");
  property p_first;
    i_reduce_req && o_amp_reduction_order && !i_first_amp_at_min |=> o_reduce_first && !o_reduce_second;
  endproperty
  a_first: assert property (p_first) else $error("first stage not reduced");
  property p_second;
    i_reduce_req && !o_amp_reduction_order && !i_second_amp_at_min |=> o_reduce_second && !o_reduce_first;
  endproperty
  a_second: assert property (p_second) else $error("second stage not reduced");
  property p_idle;
    i_rssi_valid && i_cs_clear && cs_ff[5:4] == 2'h0 && (thr == ABS_THR_DISABLED
      || int'(i_rssi) < int'(o_target_db) + int'($signed(thr))) |=> !o_carrier_sense;
  endproperty
  a_idle: assert property (p_idle) else $error("carrier sense without cause");
  property p_rel;
    s_rise |=> o_carrier_sense;
  endproperty
  a_rel: assert property (p_rel) else $error("relative rise missed");
  property p_abs;
    i_rssi_valid && thr != ABS_THR_DISABLED && int'(i_rssi) >= int'(o_target_db) + int'($signed(thr))
      |=> o_carrier_sense;
  endproperty
  a_abs: assert property (p_abs) else $error("absolute level missed");
  property p_resv;
    i_reg_rd && i_reg_addr == GAIN_PRIORITY_AND_CARRIER_SENSE_OFS |=> o_reg_rdata == ($past(cs_ff) & PRIO_CS_WRITE_MASK);
  endproperty
  a_resv: assert property (p_resv) else $error("readback wrong");
endmodule : agc_gain_cfg_monitor
bind agc_gain_cfg agc_gain_cfg_monitor u_monitor (
  .i_sys_clk             (i_sys_clk),
  .i_sys_rst             (i_sys_rst),
  .i_reg_addr            (i_reg_addr),
  .i_reg_wr              (i_reg_wr),
  .i_reg_rd              (i_reg_rd),
  .i_reg_wdata           (i_reg_wdata),
  .o_reg_rdata           (o_reg_rdata),
  .i_rssi                (i_rssi),
  .i_rssi_valid          (i_rssi_valid),
  .i_cs_clear            (i_cs_clear),
  .i_reduce_req          (i_reduce_req),
  .i_first_amp_at_min    (i_first_amp_at_min),
  .i_second_amp_at_min   (i_second_amp_at_min),
  .o_reduce_first        (o_reduce_first),
  .o_reduce_second       (o_reduce_second),
  .o_carrier_sense       (o_carrier_sense),
  .o_dig_max_step        (o_dig_max_step),
  .o_front_backoff       (o_front_backoff),
  .o_target_db           (o_target_db),
  .o_amp_reduction_order (o_amp_reduction_order)
);

// ### test/agc_gain_cfg_test.sv
// self-checking bench for the gain-limit and carrier-sense bank
// assumes the package, design and monitor are compiled first
`timescale 1ns/1ps
module agc_gain_cfg_test import agc_pkg::*;;
  logic              i_sys_clk = 1'b0, i_sys_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic              i_rssi_valid = 1'b0, i_cs_clear = 1'b0, i_reduce_req = 1'b0;
  logic              i_first_amp_at_min = 1'b0, i_second_amp_at_min = 1'b0;
  logic [ADDR_W-1:0] i_reg_addr = 6'h00;
  logic [7:0]        i_reg_wdata = 8'h00, o_reg_rdata, o_front_backoff;
  logic signed [7:0] i_rssi = 8'h00;
  logic              o_reduce_first, o_reduce_second, o_carrier_sense, o_amp_reduction_order;
  logic [2:0]        o_dig_max_step;
  logic [5:0]        o_target_db;
  int                errors = 0, samples_checked = 0;
  logic [7:0]        bo[8] = '{8'h00, 8'h1A, 8'h3D, 8'h4A, 8'h5C, 8'h73, 8'h92, 8'hAB};
  logic [7:0]        tg[8] = '{8'h18, 8'h1B, 8'h1E, 8'h21, 8'h24, 8'h26, 8'h28, 8'h2A};
  agc_gain_cfg dut (
    .i_sys_clk             (i_sys_clk),
    .i_sys_rst             (i_sys_rst),
    .i_reg_addr            (i_reg_addr),
    .i_reg_wr              (i_reg_wr),
    .i_reg_rd              (i_reg_rd),
    .i_reg_wdata           (i_reg_wdata),
    .o_reg_rdata           (o_reg_rdata),
    .i_rssi                (i_rssi),
    .i_rssi_valid          (i_rssi_valid),
    .i_cs_clear            (i_cs_clear),
    .i_reduce_req          (i_reduce_req),
    .i_first_amp_at_min    (i_first_amp_at_min),
    .i_second_amp_at_min   (i_second_amp_at_min),
    .o_reduce_first        (o_reduce_first),
    .o_reduce_second       (o_reduce_second),
    .o_carrier_sense       (o_carrier_sense),
    .o_dig_max_step        (o_dig_max_step),
    .o_front_backoff       (o_front_backoff),
    .o_target_db           (o_target_db),
    .o_amp_reduction_order (o_amp_reduction_order)
  );
  always #12.5 i_sys_clk = ~i_sys_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    {i_reg_addr, i_reg_wdata, i_reg_wr} = {a, d, 1'b1};
    @(negedge i_sys_clk);
    i_reg_wr = 1'b0;
    repeat (2) @(negedge i_sys_clk);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(negedge i_sys_clk);
    {i_reg_addr, i_reg_rd} = {a, 1'b1};
    @(negedge i_sys_clk);
    i_reg_rd = 1'b0;
    chk(o_reg_rdata, e);
  endtask : rd
  task automatic red(input logic f, input logic s, input logic [1:0] e);
    @(negedge i_sys_clk);
    {i_first_amp_at_min, i_second_amp_at_min, i_reduce_req} = {f, s, 1'b1};
    @(negedge i_sys_clk);
    i_reduce_req = 1'b0;
    chk({6'h00, o_reduce_first, o_reduce_second}, {6'h00, e});
  endtask : red
  task automatic smp(input int v, input logic c, input logic e);
    @(negedge i_sys_clk);
    {i_rssi, i_cs_clear, i_rssi_valid} = {8'(v), c, 1'b1};
    @(negedge i_sys_clk);
    {i_cs_clear, i_rssi_valid} = 2'b00;
    chk({7'h00, o_carrier_sense}, {7'h00, e});
  endtask : smp
  task automatic t_reset();
    rd(6'h1B, 8'h03);
    rd(6'h1C, 8'h40);
    rd(6'h1D, 8'h00);
    chk({5'h00, o_dig_max_step}, 8'h07);
    chk({2'h0, o_target_db}, 8'h21);
  endtask : t_reset
  task automatic t_limits();
    for (int i = 0; i < 8; i++) begin
      wr(6'h1B, {2'(i), 3'(i), 3'(i)});
      chk({5'h00, o_dig_max_step}, 8'(7 - i % 4));
      chk(o_front_backoff, bo[i]);
      chk({2'h0, o_target_db}, tg[i]);
    end
    wr(6'h1B, 8'h03);
  endtask : t_limits
  task automatic t_resv();
    wr(6'h1C, 8'hFF);
    rd(6'h1C, 8'h7F);
    wr(6'h1D, 8'h55);
    rd(6'h1B, 8'h03);
  endtask : t_resv
  task automatic t_order();
    wr(6'h1C, 8'h40);
    chk({7'h00, o_amp_reduction_order}, 8'h01);
    red(1'b0, 1'b0, 2'b10);
    red(1'b1, 1'b0, 2'b01);
    wr(6'h1C, 8'h08);
    chk({7'h00, o_amp_reduction_order}, 8'h00);
    red(1'b0, 1'b0, 2'b01);
    red(1'b0, 1'b1, 2'b10);
    red(1'b1, 1'b1, 2'b00);
  endtask : t_order
  task automatic t_rel();
    for (int c = 0; c < 4; c++) begin
      wr(6'h1C, {2'b00, 2'(c), 4'h8});
      smp(0, 1'b1, 1'b0);
      smp(1 + 4 * c, 1'b0, 1'b0);
      smp(3 + 8 * c, 1'b0, c != 0);
      smp(0, 1'b0, c != 0);
    end
  endtask : t_rel
  task automatic t_abs();
    logic [3:0] th[4] = '{4'h9, 4'h0, 4'h7, 4'h8};
    for (int i = 0; i < 4; i++) begin
      wr(6'h1C, {4'h0, th[i]});
      smp(0, 1'b1, 1'b0);
      smp(32 + int'($signed(th[i])), 1'b0, 1'b0);
      smp(33 + int'($signed(th[i])), 1'b0, i != 3);
    end
  endtask : t_abs
  task automatic results();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results
  initial begin
    repeat (10) @(negedge i_sys_clk);
    i_sys_rst = 1'b0;
    t_reset();
    t_limits();
    t_resv();
    t_order();
    t_rel();
    t_abs();
    results();
  end
  // the sequence needs well under 2000 cycles
  initial begin
    #100000;
    errors++;
    results();
  end
endmodule : agc_gain_cfg_test
